// ===== bench/host_model.sv
// Purpose: processor side of the register bus
// Assumes: one cycle per request
// Notes: released address and data lines show the inverse, not stale values
`timescale 1ns/1ps
module host_model
    import port_setup_pkg::*;
(
    input wire logic core_clk_i,
    input wire word_t rdata_i,
    output logic cs_o,
    output logic rd_o,
    output logic wr_o,
    output addr_t addr_o,
    output word_t wdata_o
);
    initial begin
        {cs_o, rd_o, wr_o, addr_o, wdata_o} = '0;
    end
    task automatic xfer(input logic w, input addr_t a, input word_t d,
        output word_t q);
        @(posedge core_clk_i);
        #1;
        {cs_o, rd_o, wr_o, addr_o, wdata_o} = {1'b1, !w, w, a, d};
        @(posedge core_clk_i);
        #1;
        {cs_o, rd_o, wr_o, addr_o, wdata_o} = {3'b0, ~a, ~d};
        q = rdata_i;
    endtask : xfer
endmodule : host_model

// ===== bench/port_setup_and_event_status_tb.sv
// Purpose: self-checking bench of the port setup block
// Assumes: 200 MHz clock
// Notes: event sources pulsed one at a time
`timescale 1ns/1ps
`include "port_setup_map.svh"
module port_setup_and_event_status_tb;
    import port_setup_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic global_irq_enable_i = 1'b0;
    logic [6:0] ev = 7'h00;
    flag_vec_t irq_enable_i = 10'h000;
    logic cs_i, rd_i, wr_i, irq_o, port_one_power_en_o;
    logic port_one_ready_o, other_ports_ready_o;
    addr_t addr_i;
    word_t wdata_i, rdata_o, q;
    int miscompares = 0;
    int comparisons = 0;
    int pos[7] = '{1, 3, 5, 6, 7, 8, 9};
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    host_model u_host_model (.core_clk_i, .rdata_i(rdata_o), .cs_o(cs_i),
        .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
    port_setup_and_event_status u_port_setup_and_event_status (
        .core_clk_i, .sys_rst_i, .cs_i, .rd_i, .wr_i, .addr_i, .wdata_i,
        .iso_done_i(ev[6]), .async_done_i(ev[5]), .periodic_done_i(ev[4]),
        .clocks_running_i(ev[3]), .suspend_i(ev[2]), .dma_end_i(ev[1]),
        .frame_start_i(ev[0]), .global_irq_enable_i, .irq_enable_i,
        .rdata_o, .irq_o, .port_one_power_en_o, .port_one_ready_o,
        .other_ports_ready_o);
    task automatic check(input word_t seen, input word_t exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input addr_t a, input word_t d);
        u_host_model.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input addr_t a);
        u_host_model.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic t_reset;
        rd(`PORT_ONE_CTRL_OFS);
        check(q, 32'h0096_0096);
        check(port_one_ready_o, 1'b1);
        check(other_ports_ready_o, 1'b1);
        check(port_one_power_en_o, 1'b0);
        wr(16'h0100, 32'hFFFF_FFFF);
        rd(16'h0100);
        check(q, 32'h0);
        rd(`EVT_STATUS_OFS);
        check(q, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ctrl;
        for (int f = 0; f < 4; f++) begin
            wr(`PORT_ONE_CTRL_OFS, 32'h80 | (32'(f) << 3));
            rd(`PORT_ONE_CTRL_OFS);
            check(port_one_power_en_o, f == 3);
            check(port_one_ready_o, 1'b0);
            check(other_ports_ready_o, 1'b1);
        end
        // Bit 7 written as one, yet the strobe must win
        wr(`PORT_ONE_CTRL_OFS, 32'h0080_0098);
        rd(`PORT_ONE_CTRL_OFS);
        check(q, 32'h0018_0018);
        check(port_one_ready_o, 1'b1);
        check(port_one_power_en_o, 1'b1);
        // Latch set again, then the plain power-on setup word
        wr(`PORT_ONE_CTRL_OFS, 32'h0000_0098);
        rd(`PORT_ONE_CTRL_OFS);
        check(q, 32'h0098_0098);
        check(port_one_ready_o, 1'b0);
        wr(`PORT_ONE_CTRL_OFS, 32'h0080_0018);
        rd(`PORT_ONE_CTRL_OFS);
        check(q, 32'h0018_0018);
        check(port_one_ready_o, 1'b1);
        check(port_one_power_en_o, 1'b1);
        $display("t_ctrl done");
    endtask : t_ctrl
    task automatic t_flags;
        wr(`EVT_STATUS_OFS, 32'h3EA);
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk_i);
            #1;
            ev[i] = 1'b1;
            @(posedge core_clk_i);
            #1;
            ev[i] = 1'b0;
            rd(`EVT_STATUS_OFS);
            check(q, 32'h1 << pos[i]);
            check(irq_o, 1'b0);
            irq_enable_i = ~(10'h1 << pos[i]);
            global_irq_enable_i = 1'b1;
            wr(`EVT_STATUS_OFS, 32'h0);
            check(irq_o, 1'b0);
            irq_enable_i = 10'h1 << pos[i];
            rd(`EVT_STATUS_OFS);
            check(q, 32'h1 << pos[i]);
            check(irq_o, 1'b1);
            wr(`EVT_STATUS_OFS, 32'h1 << pos[i]);
            rd(`EVT_STATUS_OFS);
            check(q, 32'h0);
            check(irq_o, 1'b0);
            global_irq_enable_i = 1'b0;
        end
        $display("t_flags done");
    endtask : t_flags
    task automatic summarize;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(posedge core_clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_reset();
        t_ctrl();
        t_flags();
        summarize();
    end
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
endmodule : port_setup_and_event_status_tb

// ===== bench/port_setup_chk.sv
// Purpose: port checks of the port setup block
// Assumes: one clock, sync reset
// Notes: bound to the top module
`timescale 1ns/1ps
`include "port_setup_map.svh"
module port_setup_chk
    import port_setup_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire addr_t addr_i,
    input wire word_t wdata_i,
    input wire logic iso_done_i,
    input wire logic global_irq_enable_i,
    input wire flag_vec_t irq_enable_i,
    input wire word_t rdata_o,
    input wire logic irq_o,
    input wire logic port_one_power_en_o,
    input wire logic port_one_ready_o,
    input wire logic other_ports_ready_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire cw = cs_i && wr_i && addr_i == `PORT_ONE_CTRL_OFS;
    wire cr = cs_i && rd_i && addr_i == `PORT_ONE_CTRL_OFS;
    wire ew = cs_i && wr_i && addr_i == `EVT_STATUS_OFS;
    wire er = cs_i && rd_i && addr_i == `EVT_STATUS_OFS;
    sequence s_strobe;
        cw && wdata_i[23] ##1 !wr_i;
    endsequence
    sequence s_clr;
        ew && wdata_i[9] && !iso_done_i ##1 !iso_done_i ##1 er;
    endsequence
    sequence s_iso_set;
        iso_done_i ##1 !ew ##1 er;
    endsequence
    chk_mirror_halves: assert property (cr |=>
        rdata_o[31:16] == rdata_o[15:0]) else $error("halves differ");
    chk_strobe_ready: assert property (s_strobe |=>
        port_one_ready_o) else $error("latch not cleared");
    chk_strobe_reads: assert property (s_strobe ##1 cr |=>
        !rdata_o[23] && !rdata_o[7]) else $error("strobe reads one");
    chk_other_ready: assert property ($past(!sys_rst_i) |->
        other_ports_ready_o) else $error("other ports idle");
    chk_power_field: assert property (cw ##1 !wr_i |=>
        port_one_power_en_o == ($past(wdata_i[4:3], 2) == 2'b11))
        else $error("power wrong");
    chk_flag_clear: assert property (s_clr |=> !rdata_o[9])
        else $error("flag not cleared");
    chk_flag_set: assert property (s_iso_set |=>
        rdata_o[9]) else $error("flag not set");
    chk_evt_unused: assert property (er |=>
        (rdata_o & ~{22'h0, `EVT_IMPL_MASK}) == 32'h0)
        else $error("unused bit set");
    chk_irq_gated: assert property (irq_o |->
        $past(global_irq_enable_i) && $past(|irq_enable_i))
        else $error("irq ungated");
endmodule : port_setup_chk
bind port_setup_and_event_status port_setup_chk u_port_setup_chk (
    .core_clk_i, .sys_rst_i, .cs_i, .rd_i, .wr_i, .addr_i, .wdata_i,
    .iso_done_i, .global_irq_enable_i, .irq_enable_i, .rdata_o, .irq_o,
    .port_one_power_en_o, .port_one_ready_o, .other_ports_ready_o);

// ===== pkg/port_setup_map.svh
// Purpose: offsets, field positions, reset values of the port setup block
// Assumes: byte addresses on a 16-bit address bus
// Notes:   definitions only
`ifndef PORT_SETUP_MAP_SVH
`define PORT_SETUP_MAP_SVH

`define EVT_STATUS_OFS      16'h0310
`define PORT_ONE_CTRL_OFS   16'h0374

`define EVT_ISO_BIT         9
`define EVT_ASYNC_BIT       8
`define EVT_PERIODIC_BIT    7
`define EVT_CLK_STABLE_BIT  6
`define EVT_SUSPEND_BIT     5
`define EVT_DMA_END_BIT     3
`define EVT_FRAME_BIT       1
`define EVT_WIDTH           10
`define EVT_IMPL_MASK       10'h3EA
`define EVT_RESET           10'h000

`define P1_STROBE_BIT       23
`define P1_LATCH_BIT        7
`define P1_SUPPLY_HI        4
`define P1_SUPPLY_LO        3
`define P1_SUPPLY_ON        2'h3
`define P1_CTRL_RESET       32'h0086_0016

`endif

// ===== pkg/port_setup_pkg.sv
// Purpose: shared types of the port setup block
// Assumes: constants live in port_setup_map.svh
// Notes:   types only
package port_setup_pkg;
    typedef logic [31:0] word_t;
    typedef logic [15:0] half_t;
    typedef logic [9:0] flag_vec_t;
    typedef logic [15:0] addr_t;
endpackage : port_setup_pkg

// ===== verilog/port_setup_and_event_status.sv
// Purpose: first-port control register and event status register
// Assumes: processor strobes are synchronous to core_clk_i
// Notes:   read data is registered, valid one cycle after the read strobe;
//          a read in a write cycle returns the value before the write;
//          reserved control bits store what is written;
//          the strobe's reset value of one reads back until the first write
//
// Contract
// - Port control reads give the same low and high half-words.
// - Writing one to strobe bit 23 clears strobe and latch bit 7.
// - Setup latch and strobe affect only the first port.
// - First-port power enables only when the supply field is 11b.
// - Writing one clears an event flag; zero leaves it.
// - Event flags set regardless of the global interrupt enable.
// - Flags: iso 9, async 8, periodic 7, clk 6, susp 5, dma 3, sof 1.
// - Interrupt output needs a set flag with its enable bit set.
// - Clocks-stable flag rises when clocks run stable after suspend stop.
// - Suspend-entered flag sets when the controller enters suspend.
// - List done flags set on descriptor completion events.
`timescale 1ns/1ps
`include "port_setup_map.svh"

module port_setup_and_event_status
    import port_setup_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire addr_t addr_i,
    input wire word_t wdata_i,
    input wire logic iso_done_i,
    input wire logic async_done_i,
    input wire logic periodic_done_i,
    input wire logic clocks_running_i,
    input wire logic suspend_i,
    input wire logic dma_end_i,
    input wire logic frame_start_i,
    input wire logic global_irq_enable_i,
    input wire flag_vec_t irq_enable_i,
    output word_t rdata_o,
    output logic irq_o,
    output logic port_one_power_en_o,
    output logic port_one_ready_o,
    output logic other_ports_ready_o
);
    // ********************************************
    // Access decode
    // ********************************************
    logic wr_ctrl;
    logic wr_evt;
    logic rd_ctrl;
    logic rd_evt;

    logic ctrl_hit;
    logic evt_hit;

    // Exact match only; unmapped addresses neither store nor read back
    assign ctrl_hit = cs_i && (addr_i == `PORT_ONE_CTRL_OFS);
    assign evt_hit = cs_i && (addr_i == `EVT_STATUS_OFS);
    assign wr_ctrl = ctrl_hit && wr_i;
    assign wr_evt = evt_hit && wr_i;
    assign rd_ctrl = ctrl_hit && rd_i;
    assign rd_evt = evt_hit && rd_i;

    // ********************************************
    // First-port control
    // ********************************************
    word_t ctrl_r;
    word_t ctrl_nxt;
    logic strobe_hit;

    // Strobe acts on the port one latch only
    assign strobe_hit = wr_ctrl && wdata_i[`P1_STROBE_BIT];

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = wdata_i;
            if (strobe_hit) begin
                ctrl_nxt[`P1_LATCH_BIT] = 1'b0;
                ctrl_nxt[`P1_STROBE_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl_r <= `P1_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ********************************************
    // Event status
    // ********************************************
    logic clk_run_d_r;
    logic clk_run_d_nxt;
    logic susp_d_r;
    logic susp_d_nxt;
    flag_vec_t evt_set;
    flag_vec_t evt_clr;
    flag_vec_t evt_flags;

    always_comb begin
        evt_set = '0;
        evt_set[`EVT_ISO_BIT] = iso_done_i;
        evt_set[`EVT_ASYNC_BIT] = async_done_i;
        evt_set[`EVT_PERIODIC_BIT] = periodic_done_i;
        evt_set[`EVT_CLK_STABLE_BIT] = clocks_running_i && !clk_run_d_r;
        evt_set[`EVT_SUSPEND_BIT] = suspend_i && !susp_d_r;
        evt_set[`EVT_DMA_END_BIT] = dma_end_i;
        evt_set[`EVT_FRAME_BIT] = frame_start_i;
    end

    assign evt_clr = wr_evt ? wdata_i[`EVT_WIDTH-1:0] : '0;

    // ********************************************
    // Level to edge for clock and suspend events
    // ********************************************
    always_comb begin
        clk_run_d_nxt = clocks_running_i;
        susp_d_nxt = suspend_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            // Clocks count as running after reset, so no false event
            clk_run_d_r <= 1'b1;
            susp_d_r <= 1'b0;
        end else begin
            clk_run_d_r <= clk_run_d_nxt;
            susp_d_r <= susp_d_nxt;
        end
    end

    w1c_flag_bank u_flags (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .set_i(evt_set),
        .clr_i(evt_clr),
        .flags_o(evt_flags)
    );

    // ********************************************
    // Outputs
    // ********************************************
    half_t mirror;
    word_t rdata_nxt;

    assign mirror = ctrl_r[15:0] | ctrl_r[31:16];

    // Read data stands one cycle, zero otherwise, so a stale word
    // can never be taken for a fresh one
    always_comb begin
        rdata_nxt = '0;
        if (rd_ctrl) begin
            rdata_nxt = {mirror, mirror};
        end else if (rd_evt) begin
            rdata_nxt = {22'h00_0000, evt_flags & `EVT_IMPL_MASK};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rdata_nxt;
        end
    end

    // ********************************************
    // Interrupt and port status
    // ********************************************
    flag_vec_t irq_pending;
    logic irq_nxt;
    logic pwr_nxt;
    logic p1_ready_nxt;
    logic others_ready_nxt;

    assign irq_pending = evt_flags & irq_enable_i;

    always_comb begin
        // Global enable gates the line, never the flags
        irq_nxt = global_irq_enable_i && (|irq_pending);
        pwr_nxt = ctrl_r[`P1_SUPPLY_HI:`P1_SUPPLY_LO] == `P1_SUPPLY_ON;
        p1_ready_nxt = !ctrl_r[`P1_LATCH_BIT];
        // Ports two and three need no setup step
        others_ready_nxt = 1'b1;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
            port_one_power_en_o <= 1'b0;
            port_one_ready_o <= 1'b0;
            other_ports_ready_o <= 1'b0;
        end else begin
            irq_o <= irq_nxt;
            port_one_power_en_o <= pwr_nxt;
            port_one_ready_o <= p1_ready_nxt;
            other_ports_ready_o <= others_ready_nxt;
        end
    end
endmodule : port_setup_and_event_status

// ===== verilog/w1c_flag_bank.sv
// Purpose: sticky event flags, cleared by software writing one
// Assumes: set and clear are one-cycle qualified vectors
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
`include "port_setup_map.svh"

module w1c_flag_bank
    import port_setup_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire flag_vec_t set_i,
    input wire flag_vec_t clr_i,
    output flag_vec_t flags_o
);
    localparam flag_vec_t IMPL_MASK = `EVT_IMPL_MASK;

    flag_vec_t flags_r;
    flag_vec_t flags_nxt;

    genvar g;
    generate
        for (g = 0; g < `EVT_WIDTH; g++) begin : g_flag
            always_comb begin
                if (!IMPL_MASK[g]) begin
                    // Reserved positions never hold state
                    flags_nxt[g] = 1'b0;
                end else if (set_i[g]) begin
                    flags_nxt[g] = 1'b1;
                end else if (clr_i[g]) begin
                    flags_nxt[g] = 1'b0;
                end else begin
                    flags_nxt[g] = flags_r[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            flags_r <= `EVT_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;
endmodule : w1c_flag_bank
